// ### wfd_pkg.sv
package wfd_pkg;
   localparam logic [15:0] WFD_ADDR_IRQ2 = 16'h0013;
   localparam logic [15:0] WFD_ADDR_CFG  = 16'h04A0;
   localparam logic [15:0] WFD_ADDR_STS  = 16'h04A1;
   localparam logic [15:0] WFD_ADDR_SA0  = 16'h04A2;
   localparam logic [15:0] WFD_ADDR_SA1  = 16'h04A3;
   localparam logic [15:0] WFD_ADDR_SA2  = 16'h04A4;
   localparam logic [15:0] WFD_ADDR_PW0  = 16'h04A5;
   localparam logic [15:0] WFD_ADDR_PW1  = 16'h04A6;
   localparam logic [15:0] WFD_ADDR_PW2  = 16'h04A7;
   localparam logic [15:0] WFD_ADDR_PAT  = 16'h04A8;

   localparam int WFD_CFG_MAGIC = 0;
   localparam int WFD_CFG_PAT   = 1;
   localparam int WFD_CFG_PASS  = 5;
   localparam int WFD_CFG_WAKE  = 7;
   localparam int WFD_CFG_LEVEL = 8;
   localparam int WFD_CFG_PIN   = 9;
   localparam int WFD_CFG_CLR   = 11;
   localparam logic [15:0] WFD_CFG_RST  = 16'h0000;
   localparam logic [15:0] WFD_ZERO16   = 16'h0000;

   localparam int WFD_STS_MAGIC = 0;
   localparam int WFD_STS_PAT   = 1;
   localparam int WFD_STS_PASS  = 2;
   localparam int WFD_STS_CRC   = 3;

   localparam int WFD_IRQ2_EN   = 0;
   localparam int WFD_IRQ2_FLAG = 8;

   localparam int WFD_PAT_IDX   = 8;
   localparam int WFD_PAT_MASK  = 14;

   localparam logic [7:0] WFD_SYNC_BYTE   = 8'hFF;
   localparam logic [3:0] WFD_SYNC_LEN    = 4'h6;
   localparam logic [3:0] WFD_LAST_COPY   = 4'hF;
   localparam logic [2:0] WFD_LAST_BYTE   = 3'h5;
   localparam logic [6:0] WFD_PAT_BYTES   = 7'h40;
   localparam logic [6:0] WFD_CNT_MAX     = 7'h7F;

   localparam int WFD_CLK_NS   = 25;
   localparam int WFD_PULSE_NS = 200;
   localparam logic [3:0] WFD_PULSE_CYC =
      4'((WFD_PULSE_NS + WFD_CLK_NS - 1) / WFD_CLK_NS);

   typedef enum logic [1:0] {WFD_SYNC, WFD_ADDR, WFD_PASS, WFD_HIT} wfd_mstate_t;
endpackage

// ### wfd_pat_mem.sv
`timescale 1ns/100ps
module wfd_pat_mem #(
   parameter int DEPTH = 64,
   parameter int W     = 9,
   parameter int AW    = 6
) (
   input  wire logic          clk_sys,
   input  wire logic          clk_en,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [W-1:0]  rd_data_q
);
   logic [W-1:0] mem_q [DEPTH];

   always_ff @(posedge clk_sys) begin
      if (clk_en && wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (clk_en) begin
         rd_data_q <= mem_q[rd_addr];
      end
   end
endmodule

// ### wfd_top.sv
`timescale 1ns/100ps
// Function
// (RULE_01) Inspect every addressed frame when enabled.
// (RULE_02) Addressed means own station or broadcast.
// (RULE_03) Sixteen back-to-back station address copies.
// (RULE_04) Password must follow sixteenth copy if enabled.
// (RULE_05) Copies need six 0xFF sync bytes first.
// (RULE_06) Search restarts anywhere within the frame.
// (RULE_07) Address, address-plus-password, 64-byte custom pattern.
// (RULE_08) Works at every line speed.
// (RULE_09) Bad CRC suppresses the wake indication.
// (RULE_10) Pulse or level on pin, or flag.
// (RULE_11) Configuration register selects detection behaviour.
// (RULE_12) Status register and interrupt status two.
// (RULE_13) Wake enable alone detects nothing.
// (RULE_14) Password is six bytes, in order.
// (RULE_15) Matcher returns idle at every frame end.
module wfd_top
   import wfd_pkg::*;
#(
   parameter int NGPIO = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             clk_en,
   input  wire logic             rx_dv,
   input  wire logic             rx_byte_vld,
   input  wire logic [7:0]       rx_byte,
   input  wire logic             rx_crc_err,
   input  wire logic [15:0]      mgmt_addr,
   input  wire logic [15:0]      mgmt_wdata,
   input  wire logic             mgmt_wr,
   input  wire logic             mgmt_rd,
   output logic      [15:0]      mgmt_rdata_q,
   output logic      [NGPIO-1:0] wake_gpio_q,
   output logic                  wake_irq_q
);
   import wfd_pkg::*;

   logic [15:0]  cfg_q;
   logic [47:0]  sa_q;
   logic [47:0]  pw_q;
   logic [3:0]   sts_q;
   logic         irq_en_q;
   logic         irq_flag_q;
   logic         rx_dv_q;
   logic [6:0]   byte_cnt_q;
   logic         da_node_q;
   logic         da_bcast_q;
   logic         pat_ok_q;
   wfd_mstate_t  mst_q;
   logic [3:0]   cnt_q;
   logic [2:0]   idx_q;
   logic [3:0]   pulse_cnt_q;
   logic         level_q;
   logic [8:0]   pat_rd;
   logic         bv;
   logic         frame_end;
   logic         hit_magic;
   logic         hit_pat;
   logic         qualified;
   logic         wake_evt;
   logic         crc_rej;
   logic         wr_cfg;
   logic         rd_sts;
   logic         rd_irq2;
   logic [7:0]   sa_exp;
   logic [7:0]   pw_exp;
   logic [3:0]   restart_cnt;

   function automatic logic [7:0] byte_of(input logic [47:0] v, input logic [2:0] i);
      byte_of = v[8*(5-int'(i)) +: 8];
   endfunction

   // Bytes arrive as strobes, so the line speed only changes their spacing.
   assign bv        = clk_en && rx_dv && rx_byte_vld; // RULE_08
   assign frame_end = clk_en && rx_dv_q && !rx_dv;
   assign wr_cfg    = clk_en && mgmt_wr && mgmt_addr == WFD_ADDR_CFG;
   assign rd_sts    = clk_en && mgmt_rd && mgmt_addr == WFD_ADDR_STS;
   assign rd_irq2   = clk_en && mgmt_rd && mgmt_addr == WFD_ADDR_IRQ2;
   assign sa_exp    = byte_of(sa_q, idx_q);
   assign pw_exp    = byte_of(pw_q, idx_q);
   assign restart_cnt = (rx_byte == WFD_SYNC_BYTE) ? 4'h1 : 4'h0;

   assign hit_magic = cfg_q[WFD_CFG_MAGIC] && mst_q == WFD_HIT; // RULE_07
   assign hit_pat   = cfg_q[WFD_CFG_PAT] && pat_ok_q && byte_cnt_q >= WFD_PAT_BYTES; // RULE_07
   // The wake bit on its own arms nothing; a frame type must also be chosen.
   assign qualified = cfg_q[WFD_CFG_WAKE] && (hit_magic || hit_pat) // RULE_13 RULE_11
                      && (da_node_q || da_bcast_q); // RULE_02 RULE_01
   assign wake_evt  = frame_end && qualified && !rx_crc_err; // RULE_09
   assign crc_rej   = frame_end && qualified && rx_crc_err; // RULE_09

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cfg_q <= WFD_CFG_RST;
         sa_q  <= '0;
         pw_q  <= '0;
         irq_en_q <= 1'b0;
      end else if (clk_en && mgmt_wr) begin
         case (mgmt_addr)
            WFD_ADDR_CFG: begin
               cfg_q <= mgmt_wdata; // RULE_11
               cfg_q[WFD_CFG_CLR] <= 1'b0;
            end
            WFD_ADDR_SA0:  sa_q[47:32] <= mgmt_wdata;
            WFD_ADDR_SA1:  sa_q[31:16] <= mgmt_wdata;
            WFD_ADDR_SA2:  sa_q[15:0]  <= mgmt_wdata;
            WFD_ADDR_PW0:  pw_q[47:32] <= mgmt_wdata;
            WFD_ADDR_PW1:  pw_q[31:16] <= mgmt_wdata;
            WFD_ADDR_PW2:  pw_q[15:0]  <= mgmt_wdata;
            WFD_ADDR_IRQ2: irq_en_q    <= mgmt_wdata[WFD_IRQ2_EN];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         mgmt_rdata_q <= WFD_ZERO16;
      end else if (clk_en && mgmt_rd) begin
         case (mgmt_addr)
            WFD_ADDR_CFG:  mgmt_rdata_q <= cfg_q;
            WFD_ADDR_STS:  mgmt_rdata_q <= {12'h000, sts_q}; // RULE_12
            WFD_ADDR_IRQ2: mgmt_rdata_q <= {7'h00, irq_flag_q, 7'h00, irq_en_q}; // RULE_12
            WFD_ADDR_SA0:  mgmt_rdata_q <= sa_q[47:32];
            WFD_ADDR_SA1:  mgmt_rdata_q <= sa_q[31:16];
            WFD_ADDR_SA2:  mgmt_rdata_q <= sa_q[15:0];
            WFD_ADDR_PW0:  mgmt_rdata_q <= pw_q[47:32];
            WFD_ADDR_PW1:  mgmt_rdata_q <= pw_q[31:16];
            WFD_ADDR_PW2:  mgmt_rdata_q <= pw_q[15:0];
            default:       mgmt_rdata_q <= WFD_ZERO16;
         endcase
      end
   end

   // Status bits are sticky and clear on read; a new event in the read cycle wins.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sts_q <= 4'h0;
      end else if (clk_en) begin
         sts_q <= (rd_sts ? 4'h0 : sts_q)
                  | {crc_rej,
                     wake_evt && hit_magic && cfg_q[WFD_CFG_PASS],
                     wake_evt && hit_pat,
                     wake_evt && hit_magic}; // RULE_12
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irq_flag_q <= 1'b0;
         wake_irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_flag_q <= wake_evt || (irq_flag_q && !rd_irq2); // RULE_10
         wake_irq_q <= irq_flag_q && irq_en_q; // RULE_12
      end
   end

   // Frame bookkeeping: destination check and byte position.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rx_dv_q    <= 1'b0;
         byte_cnt_q <= 7'h00;
         da_node_q  <= 1'b1;
         da_bcast_q <= 1'b1;
      end else if (clk_en) begin
         rx_dv_q <= rx_dv;
         if (!rx_dv) begin
            byte_cnt_q <= 7'h00;
            da_node_q  <= 1'b1;
            da_bcast_q <= 1'b1;
         end else if (bv) begin
            if (byte_cnt_q != WFD_CNT_MAX) begin
               byte_cnt_q <= byte_cnt_q + 7'h01;
            end
            if (byte_cnt_q <= 7'(WFD_LAST_BYTE)) begin
               if (rx_byte != byte_of(sa_q, byte_cnt_q[2:0])) begin
                  da_node_q <= 1'b0; // RULE_02
               end
               if (rx_byte != WFD_SYNC_BYTE) begin
                  da_bcast_q <= 1'b0; // RULE_02
               end
            end
         end
      end
   end

   // Custom pattern: one stored byte and don't-care mask per frame position.
   // The read is registered, so byte strobes must be at least two cycles apart.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pat_ok_q <= 1'b1;
      end else if (clk_en) begin
         if (!rx_dv) begin
            pat_ok_q <= 1'b1;
         end else if (bv && byte_cnt_q < WFD_PAT_BYTES && !pat_rd[8]
                      && rx_byte != pat_rd[7:0]) begin
            pat_ok_q <= 1'b0; // RULE_07
         end
      end
   end

   wfd_pat_mem #(
      .DEPTH (64),
      .W     (9),
      .AW    (6)
   ) u_pat_mem (
      .clk_sys   (clk_sys),
      .clk_en    (clk_en),
      .wr_en     (mgmt_wr && mgmt_addr == WFD_ADDR_PAT),
      .wr_addr   (mgmt_wdata[WFD_PAT_IDX +: 6]),
      .wr_data   ({mgmt_wdata[WFD_PAT_MASK], mgmt_wdata[7:0]}),
      .rd_addr   (byte_cnt_q[5:0]),
      .rd_data_q (pat_rd)
   );

   // Sync run, sixteen address copies, optional password.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         mst_q <= WFD_SYNC;
         cnt_q <= 4'h0;
         idx_q <= 3'h0;
      end else if (clk_en) begin
         if (!rx_dv) begin
            mst_q <= WFD_SYNC; // RULE_15
            cnt_q <= 4'h0;
            idx_q <= 3'h0;
         end else if (bv) begin
            case (mst_q)
               WFD_SYNC: begin
                  if (rx_byte == WFD_SYNC_BYTE) begin
                     if (cnt_q != WFD_SYNC_LEN) begin
                        cnt_q <= cnt_q + 4'h1;
                     end
                  end else if (cnt_q == WFD_SYNC_LEN && rx_byte == byte_of(sa_q, 3'h0)) begin
                     mst_q <= WFD_ADDR; // RULE_05
                     cnt_q <= 4'h0;
                     idx_q <= 3'h1;
                  end else begin
                     cnt_q <= 4'h0; // RULE_06
                  end
               end
               WFD_ADDR: begin
                  if (rx_byte == sa_exp) begin
                     if (idx_q == WFD_LAST_BYTE) begin
                        idx_q <= 3'h0;
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == WFD_LAST_COPY) begin
                           mst_q <= cfg_q[WFD_CFG_PASS] ? WFD_PASS : WFD_HIT; // RULE_03 RULE_04
                        end
                     end else begin
                        idx_q <= idx_q + 3'h1;
                     end
                  end else begin
                     mst_q <= WFD_SYNC; // RULE_03 RULE_06
                     idx_q <= 3'h0;
                     cnt_q <= restart_cnt;
                  end
               end
               WFD_PASS: begin
                  if (rx_byte == pw_exp) begin
                     if (idx_q == WFD_LAST_BYTE) begin
                        mst_q <= WFD_HIT; // RULE_14
                     end else begin
                        idx_q <= idx_q + 3'h1;
                     end
                  end else begin
                     mst_q <= WFD_SYNC; // RULE_14 RULE_06
                     idx_q <= 3'h0;
                     cnt_q <= restart_cnt;
                  end
               end
               WFD_HIT: ;
               default: mst_q <= WFD_SYNC;
            endcase
         end
      end
   end

   // Wake output: a fixed-width pulse, or a level held until software clears it.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pulse_cnt_q <= 4'h0;
         level_q     <= 1'b0;
         wake_gpio_q <= '0;
      end else if (clk_en) begin
         if (wake_evt && !cfg_q[WFD_CFG_LEVEL]) begin
            pulse_cnt_q <= WFD_PULSE_CYC; // RULE_10
         end else if (pulse_cnt_q != 4'h0) begin
            pulse_cnt_q <= pulse_cnt_q - 4'h1;
         end
         if (wake_evt && cfg_q[WFD_CFG_LEVEL]) begin
            level_q <= 1'b1; // RULE_10
         end else if (wr_cfg && mgmt_wdata[WFD_CFG_CLR]) begin
            level_q <= 1'b0;
         end
         for (int i = 0; i < NGPIO; i++) begin
            wake_gpio_q[i] <= (int'(cfg_q[WFD_CFG_PIN +: 2]) == i)
                              && (level_q || pulse_cnt_q != 4'h0); // RULE_10
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_evt_pulse;
      wake_evt && !cfg_q[WFD_CFG_LEVEL];
   endsequence
   // A frozen cycle may delay the pin, so the check only binds while the clock is enabled.
   sequence s_pulse_run;
      pulse_cnt_q == WFD_PULSE_CYC
      ##1 (!clk_en || (|wake_gpio_q) || int'(cfg_q[WFD_CFG_PIN +: 2]) >= NGPIO);
   endsequence

   crc_gate_a: assert property ((frame_end && rx_crc_err && !irq_flag_q) |=> !irq_flag_q) // RULE_09
      else $error("wake flag set by frame with CRC error");
   wake_alone_a: assert property ((frame_end && !cfg_q[WFD_CFG_MAGIC] && !cfg_q[WFD_CFG_PAT] // RULE_13
      && !irq_flag_q) |=> !irq_flag_q)
      else $error("wake flag set with no frame type enabled");
   addr_qual_a: assert property ((frame_end && !da_node_q && !da_bcast_q && !irq_flag_q) // RULE_02
      |=> !irq_flag_q)
      else $error("wake flag set by frame not addressed to node");
   idle_reset_a: assert property ((clk_en && !rx_dv) |=> (mst_q == WFD_SYNC && cnt_q == 4'h0)) // RULE_15
      else $error("matcher not idle after frame end");
   sync_first_a: assert property ((bv && mst_q == WFD_SYNC && cnt_q != WFD_SYNC_LEN) // RULE_05
      |=> mst_q == WFD_SYNC)
      else $error("address copies accepted without full sync run");
   copy_count_a: assert property ((bv && mst_q == WFD_ADDR // RULE_03
      && !(cnt_q == WFD_LAST_COPY && idx_q == WFD_LAST_BYTE)) |=> mst_q inside {WFD_ADDR, WFD_SYNC})
      else $error("address run ended before sixteen copies");
   password_a: assert property ((clk_en && mst_q == WFD_ADDR && cfg_q[WFD_CFG_PASS]) // RULE_04
      |=> mst_q != WFD_HIT)
      else $error("match declared without password");
   pulse_out_a: assert property (s_evt_pulse |=> s_pulse_run) // RULE_10
      else $error("wake pulse not produced");
   irq_out_a: assert property ((clk_en && irq_flag_q && irq_en_q) |=> wake_irq_q) // RULE_12
      else $error("wake interrupt output not raised");
endmodule

// ### wfd_host_model.sv
`timescale 1ns/100ps
module wfd_host_model #(
   parameter int NGPIO = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic [NGPIO-1:0] wake_gpio,
   input  wire logic             wake_irq,
   output int                    rises,
   output int                    width,
   output int                    irq_rises
);
   // The sleeping controller only counts wake edges and measures how long the pin stayed up.
   int          run_q;
   logic        pin_q;
   logic        irq_q;

   always @(posedge clk_sys) begin
      if (!rstn) begin
         rises = 0;
         width = 0;
         irq_rises = 0;
         run_q = 0;
         pin_q = 1'b0;
         irq_q = 1'b0;
      end else begin
         if ((|wake_gpio) && !pin_q) begin
            rises = rises + 1;
         end
         if (|wake_gpio) begin
            run_q = run_q + 1;
         end else if (pin_q) begin
            width = run_q;
            run_q = 0;
         end
         if (wake_irq && !irq_q) begin
            irq_rises = irq_rises + 1;
         end
         pin_q = |wake_gpio;
         irq_q = wake_irq;
      end
   end
endmodule

// ### wake_frame_detector_test.sv
`timescale 1ns/100ps
module wake_frame_detector_test;
   import wfd_pkg::*;
   logic        clk_sys, rstn, clk_en, rx_dv, rx_byte_vld, rx_crc_err, mgmt_wr, mgmt_rd;
   logic [7:0]  rx_byte;
   logic [15:0] mgmt_addr, mgmt_wdata, mgmt_rdata_q, v;
   logic [2:0]  wake_gpio_q;
   logic        wake_irq_q;
   int          errors, samples_checked, cycles, rises, width, irq_rises, r0;
   logic [7:0]  fq[$];
   logic [7:0]  sa[6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
   logic [7:0]  pw[6] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F};

   wfd_top wfd_top_inst (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .rx_dv(rx_dv),
      .rx_byte_vld(rx_byte_vld), .rx_byte(rx_byte), .rx_crc_err(rx_crc_err),
      .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
      .mgmt_rdata_q(mgmt_rdata_q), .wake_gpio_q(wake_gpio_q), .wake_irq_q(wake_irq_q));
   wfd_host_model wfd_host_model_inst (.clk_sys(clk_sys), .rstn(rstn), .wake_gpio(wake_gpio_q),
      .wake_irq(wake_irq_q), .rises(rises), .width(width), .irq_rises(irq_rises));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic wrap_up();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // The ceiling allows several times the expected run of about 5300 cycles.
   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         errors = errors + 1;
         $display("[FAIL] timeout expected finish seen hang");
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      mgmt_addr = a;
      mgmt_wdata = d;
      mgmt_wr = 1'b1;
      @(negedge clk_sys);
      mgmt_wr = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge clk_sys);
      mgmt_addr = a;
      mgmt_rd = 1'b1;
      @(negedge clk_sys);
      mgmt_rd = 1'b0;
      d = mgmt_rdata_q;
   endtask

   // Builds a frame: header, a stray byte, seven sync bytes, address copies and a password.
   task automatic mk(input bit bc, input int copies, input int npw);
      fq.delete();
      for (int i = 0; i < 6; i++) fq.push_back(bc ? 8'hFF : sa[i]);
      repeat (6) fq.push_back(8'h02);
      fq.push_back(8'h55);
      repeat (7) fq.push_back(8'hFF);
      for (int c = 0; c < copies; c++) foreach (sa[i]) fq.push_back(sa[i]);
      for (int i = 0; i < 6 && npw > 0; i++) fq.push_back((npw == 2 && i == 5) ? 8'h00 : pw[i]);
      repeat (4) fq.push_back(8'h00);
   endtask

   task automatic send(input int gap, input logic crc);
      @(negedge clk_sys);
      rx_dv = 1'b1;
      foreach (fq[i]) begin
         @(negedge clk_sys);
         rx_byte = fq[i];
         rx_byte_vld = 1'b1;
         @(negedge clk_sys);
         rx_byte_vld = 1'b0;
         repeat (gap - 2) @(negedge clk_sys);
      end
      rx_dv = 1'b0;
      rx_crc_err = crc;
      @(negedge clk_sys);
      rx_crc_err = 1'b0;
      repeat (12) @(negedge clk_sys);
   endtask

   task automatic t_reset();
      rd(WFD_ADDR_CFG, v);
      chk("config reset", 16'h0000, v);
      rd(WFD_ADDR_STS, v);
      chk("status reset", 16'h0000, v);
      rd(WFD_ADDR_IRQ2, v);
      chk("irq2 reset", 16'h0000, v);
      rd(16'h0100, v);
      chk("unmapped read", 16'h0000, v);
      chk("gpio reset", 16'h0000, {13'h0000, wake_gpio_q});
   endtask

   task automatic t_enable_only();
      wr(WFD_ADDR_CFG, 16'h0080);
      r0 = rises;
      mk(1'b0, 16, 0);
      send(3, 1'b0);
      chk("wake enable alone", 16'h0000, 16'(rises - r0));
      rd(WFD_ADDR_STS, v);
      chk("status enable alone", 16'h0000, v);
   endtask

   task automatic t_magic();
      wr(WFD_ADDR_CFG, 16'h0081);
      r0 = rises;
      mk(1'b0, 16, 0);
      send(3, 1'b0);
      chk("rep frame rises", 16'h0001, 16'(rises - r0));
      chk("pulse width", 16'h0008, 16'(width));
      chk("irq level", 16'h0001, {15'h0000, wake_irq_q});
      rd(WFD_ADDR_STS, v);
      chk("status rep", 16'h0001, v);
      rd(WFD_ADDR_IRQ2, v);
      chk("irq2 flag", 16'h0101, v);
      @(negedge clk_sys);
      chk("irq cleared", 16'h0000, {15'h0000, wake_irq_q});
      mk(1'b1, 16, 0);
      send(10, 1'b0);
      chk("broadcast slow", 16'h0002, 16'(rises - r0));
      rd(WFD_ADDR_STS, v);
      chk("status broadcast", 16'h0001, v);
      rd(WFD_ADDR_IRQ2, v);
   endtask

   task automatic t_reject();
      @(negedge clk_sys);
      clk_en = 1'b0;
      wr(WFD_ADDR_CFG, 16'h0000);
      clk_en = 1'b1;
      rd(WFD_ADDR_CFG, v);
      chk("frozen write", 16'h0081, v);
      r0 = rises;
      mk(1'b0, 16, 0);
      send(3, 1'b1);
      chk("crc rises", 16'h0000, 16'(rises - r0));
      rd(WFD_ADDR_STS, v);
      chk("status crc", 16'h0008, v);
      mk(1'b0, 15, 0);
      send(3, 1'b0);
      chk("fifteen copies", 16'h0000, 16'(rises - r0));
      rd(WFD_ADDR_STS, v);
      chk("status fifteen", 16'h0000, v);
      mk(1'b0, 16, 0);
      fq[0] = 8'h01;
      send(3, 1'b0);
      chk("foreign address", 16'h0000, 16'(rises - r0));
      rd(WFD_ADDR_STS, v);
      chk("status foreign", 16'h0000, v);
   endtask

   task automatic t_password();
      wr(WFD_ADDR_CFG, 16'h03A1);
      r0 = rises;
      for (int k = 0; k < 2; k++) begin
         mk(1'b0, 16, k * 2);
         send(3, 1'b0);
         chk("bad or missing password", 16'h0000, 16'(rises - r0));
      end
      mk(1'b0, 16, 1);
      send(4, 1'b0);
      chk("password level pin", 16'h0002, {13'h0000, wake_gpio_q});
      rd(WFD_ADDR_STS, v);
      chk("status password", 16'h0004, v & 16'h0004);
      wr(WFD_ADDR_CFG, 16'h0BA1);
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk("level cleared", 16'h0000, {13'h0000, wake_gpio_q});
      rd(WFD_ADDR_IRQ2, v);
   endtask

   task automatic t_pattern();
      wr(WFD_ADDR_CFG, 16'h0082);
      for (int i = 0; i < 64; i++) begin
         wr(WFD_ADDR_PAT, (i < 6) ? {2'b00, 6'(i), sa[i]} : {2'b01, 6'(i), 8'h00});
      end
      r0 = rises;
      // The pattern needs at least 64 frame bytes, so the long frame is reused.
      mk(1'b0, 16, 0);
      send(3, 1'b0);
      chk("pattern rises", 16'h0001, 16'(rises - r0));
      rd(WFD_ADDR_STS, v);
      chk("status pattern", 16'h0002, v);
      mk(1'b1, 16, 0);
      send(3, 1'b0);
      chk("pattern mismatch", 16'h0001, 16'(rises - r0));
   endtask

   initial begin
      errors = 0;
      samples_checked = 0;
      cycles = 0;
      rstn = 1'b0;
      clk_en = 1'b1;
      rx_dv = 1'b0;
      rx_byte_vld = 1'b0;
      rx_byte = 8'h00;
      rx_crc_err = 1'b0;
      mgmt_addr = 16'h0000;
      mgmt_wdata = 16'h0000;
      mgmt_wr = 1'b0;
      mgmt_rd = 1'b0;
      repeat (6) @(negedge clk_sys);
      rstn = 1'b1;
      t_reset();
      wr(WFD_ADDR_SA0, 16'h1122);
      wr(WFD_ADDR_SA1, 16'h3344);
      wr(WFD_ADDR_SA2, 16'h5566);
      wr(WFD_ADDR_PW0, 16'h2A2B);
      wr(WFD_ADDR_PW1, 16'h2C2D);
      wr(WFD_ADDR_PW2, 16'h2E2F);
      wr(WFD_ADDR_IRQ2, 16'h0001);
      t_enable_only();
      t_magic();
      t_reject();
      t_password();
      t_pattern();
      wrap_up();
   end
endmodule
